/* itc_defs.vh */
`ifndef ITC_DEFS_VH
`define ITC_DEFS_VH

// Register offsets (word addresses)
`define ITC_OFS_PEND2 5'h13
`define ITC_OFS_PEND3 5'h14
`define ITC_OFS_PEND4 5'h15
`define ITC_OFS_PEND5 5'h16
`define ITC_OFS_CTRL 5'h1D
`define ITC_OFS_CAN2PRI 5'h1F

// Control register fields
`define ITC_CTRL_INT_BIT 15
`define ITC_CTRL_LVL_HI 14
`define ITC_CTRL_LVL_LO 13
`define ITC_CTRL_VEC_HI 12
`define ITC_CTRL_VEC_LO 6
`define ITC_CTRL_DIS_BIT 5
`define ITC_CTRL_RSV_BIT 4
`define ITC_CTRL_BLVL_BIT 3
`define ITC_CTRL_ALVL_BIT 2
`define ITC_CTRL_BEDG_BIT 1
`define ITC_CTRL_AEDG_BIT 0

// CAN2 priority fields
`define ITC_PRI_MSGBUF_LO 6
`define ITC_PRI_WAKEUP_LO 4
`define ITC_PRI_ERROR_LO 2
`define ITC_PRI_BUSOFF_LO 0

// Reset values
`define ITC_RST_CAN2PRI 8'h00
`define ITC_RST_DIS 1'b0
`define ITC_RST_EDGE 1'b0

// Priority encodings
`define ITC_PRI_DISABLED 2'b00
`define ITC_CODE_FIXED 3'h4

// Vector numbering of the covered pending range
`define ITC_FIRST_VEC 7'h21
`define ITC_NUM_SRC 53
`define ITC_PEND5_USED 5

// Source indices (vector minus 33)
`define ITC_IDX_EXT_A 6'h00
`define ITC_IDX_EXT_B 6'h01
`define ITC_IDX_CAN2_BUSOFF 6'h31
`define ITC_IDX_CAN2_ERROR 6'h32
`define ITC_IDX_CAN2_WAKEUP 6'h33
`define ITC_IDX_CAN2_MSGBUF 6'h34

// Reset vector number placed on the address bus
`define ITC_RESET_VEC 8'h00

// Core sees the reset vector up to this many edges after release
`define ITC_RESET_HOLD_EDGES 2

`endif

/* itc_pending_ctrl.v */
`timescale 1ns/1ns
`include "itc_defs.vh"

// How it works
// RULE_01 - Pending bits read 0 when request pending
// RULE_02 - Words 2..4 hold positions 33 to 80
// RULE_03 - Word 5 holds positions 81 to 85
// RULE_04 - Word 5 upper bits read 1, unwritable
// RULE_05 - Control bit 15 shows interrupt to core
// RULE_06 - Bits 14:13 report new taken priority level
// RULE_07 - Bits 12:6 hold last taken vector number
// RULE_08 - Taken fields update only on core jump
// RULE_09 - Bit 5 set blocks all core requests
// RULE_10 - Control bit 4 reads 1, unwritable
// RULE_11 - Bits 3:2 mirror external pin levels
// RULE_12 - Bits 1:0 select level or falling edge
// RULE_13 - Stop or wait forces level sensing
// RULE_14 - Priority field 00 disabled, else level 1..3
// RULE_15 - Fields msgbuf 7:6, wakeup 5:4, error 3:2, busoff 1:0
// RULE_16 - Priority bits 15:8 read 0, unwritable
// RULE_17 - Reset vector until second edge after release
// RULE_18 - Reset disables all but fixed core sources
// RULE_19 - Vector base forms upper 13 address bits
// RULE_20 - Highest enabled request wins, ties lower vector
module itc_pending_ctrl #(
  parameter NUM_SRC = `ITC_NUM_SRC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Peripheral requests, active high, index 0 is vector 33
  input wire [NUM_SRC-1:0] src_req,
  // Priority codes of sources whose priority registers live elsewhere
  input wire [2*NUM_SRC-1:0] src_level,
  // Core fixed-priority sources
  input wire core_fixed_req,
  input wire [6:0] core_fixed_vec,
  // External request pins, active low, asynchronous
  input wire ext_request_a_pin_n,
  input wire ext_request_b_pin_n,
  // Low-power state of the chip
  input wire stop_wait_mode,
  // Vector base from its own register
  input wire [12:0] vector_base,
  // Core side
  input wire core_take,
  output reg irq_to_core,
  output reg [1:0] irq_level_to_core,
  output reg [20:0] vector_addr,
  output reg reset_vector_valid
);

  // Register state
  reg [7:0] can2_priority_levels_ff;
  reg global_irq_disable_ff;
  reg ext_a_edge_select_ff;
  reg ext_b_edge_select_ff;
  reg [1:0] taken_priority_level_ff;
  reg [6:0] taken_vector_number_ff;
  reg [6:0] cur_vec_ff;
  reg rst_hold_done_ff;
  reg [NUM_SRC-1:0] pend_ff;

  // Pin synchronisers and edge latches
  reg pin_a_meta_ff;
  reg pin_a_sync_ff;
  reg pin_a_prev_ff;
  reg pin_b_meta_ff;
  reg pin_b_sync_ff;
  reg pin_b_prev_ff;
  reg edge_a_ff;
  reg edge_b_ff;

  wire eff_edge_a;
  wire eff_edge_b;
  wire fall_a;
  wire fall_b;
  wire clr_a;
  wire clr_b;
  wire nxt_edge_a;
  wire nxt_edge_b;

  reg [NUM_SRC-1:0] nxt_pend;
  reg [2:0] best_code;
  reg [6:0] best_vec;
  reg nxt_irq;
  reg [1:0] nxt_level;
  reg [20:0] nxt_vector_addr;
  reg [15:0] nxt_rdata;
  integer i;

  // Priority code of one source, 0 when disabled
  function [2:0] code_of;
    input [5:0] idx;
    input [7:0] can2;
    input [2*NUM_SRC-1:0] lvl;
    begin
      case (idx)
        `ITC_IDX_CAN2_MSGBUF: code_of = {1'b0, can2[`ITC_PRI_MSGBUF_LO+1:`ITC_PRI_MSGBUF_LO]}; // see RULE_15
        `ITC_IDX_CAN2_WAKEUP: code_of = {1'b0, can2[`ITC_PRI_WAKEUP_LO+1:`ITC_PRI_WAKEUP_LO]}; // see RULE_15
        `ITC_IDX_CAN2_ERROR: code_of = {1'b0, can2[`ITC_PRI_ERROR_LO+1:`ITC_PRI_ERROR_LO]}; // see RULE_15
        `ITC_IDX_CAN2_BUSOFF: code_of = {1'b0, can2[`ITC_PRI_BUSOFF_LO+1:`ITC_PRI_BUSOFF_LO]}; // see RULE_15
        default: code_of = {1'b0, lvl[2*idx+:2]};
      endcase
    end
  endfunction

  // Low-power modes have no clock for edge detection, so pins fall back to level
  assign eff_edge_a = ext_a_edge_select_ff & ~stop_wait_mode; // see RULE_13
  assign eff_edge_b = ext_b_edge_select_ff & ~stop_wait_mode; // see RULE_13
  assign fall_a = pin_a_prev_ff & ~pin_a_sync_ff;
  assign fall_b = pin_b_prev_ff & ~pin_b_sync_ff;
  assign clr_a = core_take & irq_to_core & (cur_vec_ff == `ITC_FIRST_VEC + {1'b0, `ITC_IDX_EXT_A});
  assign clr_b = core_take & irq_to_core & (cur_vec_ff == `ITC_FIRST_VEC + {1'b0, `ITC_IDX_EXT_B});
  // A new falling edge in the clearing cycle wins over the clear
  assign nxt_edge_a = eff_edge_a & (fall_a | (edge_a_ff & ~clr_a)); // see RULE_12
  assign nxt_edge_b = eff_edge_b & (fall_b | (edge_b_ff & ~clr_b)); // see RULE_12

  always @*
  begin
    nxt_pend = src_req;
    nxt_pend[`ITC_IDX_EXT_A] = eff_edge_a ? nxt_edge_a : ~pin_a_sync_ff; // see RULE_12
    nxt_pend[`ITC_IDX_EXT_B] = eff_edge_b ? nxt_edge_b : ~pin_b_sync_ff; // see RULE_12
  end

  // Arbitration: strict greater-than keeps the lower vector on a tie
  always @*
  begin
    best_code = 3'h0;
    best_vec = 7'h00;
    for (i = 0; i < NUM_SRC; i = i + 1)
    begin
      if (pend_ff[i] && (code_of(i[5:0], can2_priority_levels_ff, src_level) > best_code)) // see RULE_20
      begin
        best_code = code_of(i[5:0], can2_priority_levels_ff, src_level); // see RULE_14
        best_vec = `ITC_FIRST_VEC + i[6:0];
      end
    end
    if (core_fixed_req) // see RULE_18
    begin
      best_code = `ITC_CODE_FIXED;
      best_vec = core_fixed_vec;
    end
  end

  always @*
  begin
    nxt_irq = (best_code != 3'h0) & ~global_irq_disable_ff & rst_hold_done_ff; // see RULE_09
    nxt_level = (best_code == `ITC_CODE_FIXED) ? 2'b11 : best_code[1:0]; // see RULE_06
    nxt_vector_addr = {vector_base, best_vec, 1'b0}; // see RULE_19
    if (!rst_hold_done_ff)
      nxt_vector_addr = {vector_base, `ITC_RESET_VEC}; // see RULE_17
  end

  // Read mux
  always @*
  begin
    nxt_rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `ITC_OFS_PEND2: nxt_rdata = ~pend_ff[15:0]; // see RULE_02
        `ITC_OFS_PEND3: nxt_rdata = ~pend_ff[31:16]; // see RULE_02
        `ITC_OFS_PEND4: nxt_rdata = ~pend_ff[47:32]; // see RULE_01
        `ITC_OFS_PEND5: nxt_rdata = {{(16-`ITC_PEND5_USED){1'b1}}, ~pend_ff[52:48]}; // see RULE_03 RULE_04
        `ITC_OFS_CTRL: nxt_rdata = {irq_to_core, taken_priority_level_ff, // see RULE_05
          taken_vector_number_ff, global_irq_disable_ff, 1'b1, // see RULE_10
          pin_b_sync_ff, pin_a_sync_ff, ext_b_edge_select_ff, ext_a_edge_select_ff}; // see RULE_11
        `ITC_OFS_CAN2PRI: nxt_rdata = {8'h00, can2_priority_levels_ff}; // see RULE_16
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_a_meta_ff <= 1'b1;
      pin_a_sync_ff <= 1'b1;
      pin_a_prev_ff <= 1'b1;
      pin_b_meta_ff <= 1'b1;
      pin_b_sync_ff <= 1'b1;
      pin_b_prev_ff <= 1'b1;
    end
    else
    begin
      pin_a_meta_ff <= ext_request_a_pin_n;
      pin_a_sync_ff <= pin_a_meta_ff;
      pin_a_prev_ff <= pin_a_sync_ff;
      pin_b_meta_ff <= ext_request_b_pin_n;
      pin_b_sync_ff <= pin_b_meta_ff;
      pin_b_prev_ff <= pin_b_sync_ff;
    end
  end

  // Registers written by software
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      can2_priority_levels_ff <= `ITC_RST_CAN2PRI; // see RULE_18
      global_irq_disable_ff <= `ITC_RST_DIS;
      ext_a_edge_select_ff <= `ITC_RST_EDGE;
      ext_b_edge_select_ff <= `ITC_RST_EDGE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ITC_OFS_CAN2PRI)
        can2_priority_levels_ff <= reg_wdata[7:0]; // see RULE_16
      if (reg_addr == `ITC_OFS_CTRL)
      begin
        global_irq_disable_ff <= reg_wdata[`ITC_CTRL_DIS_BIT]; // see RULE_09
        ext_b_edge_select_ff <= reg_wdata[`ITC_CTRL_BEDG_BIT]; // see RULE_12
        ext_a_edge_select_ff <= reg_wdata[`ITC_CTRL_AEDG_BIT]; // see RULE_12
      end
    end
  end

  // Request state and core handshake
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_ff <= {NUM_SRC{1'b0}};
      edge_a_ff <= 1'b0;
      edge_b_ff <= 1'b0;
      irq_to_core <= 1'b0;
      irq_level_to_core <= 2'b00;
      cur_vec_ff <= 7'h00;
      vector_addr <= {13'h0000, `ITC_RESET_VEC}; // see RULE_17
      reset_vector_valid <= 1'b1;
      rst_hold_done_ff <= 1'b0;
      taken_priority_level_ff <= 2'b00;
      taken_vector_number_ff <= 7'h00;
    end
    else
    begin
      pend_ff <= nxt_pend;
      edge_a_ff <= nxt_edge_a;
      edge_b_ff <= nxt_edge_b;
      // First edge after release sets the flag; the second moves off the reset vector
      rst_hold_done_ff <= 1'b1; // see RULE_17
      reset_vector_valid <= ~rst_hold_done_ff;
      irq_to_core <= nxt_irq; // see RULE_20
      irq_level_to_core <= nxt_level;
      cur_vec_ff <= best_vec;
      vector_addr <= nxt_vector_addr;
      // Capture only when the core jumps, so nesting may overwrite unread values
      if (core_take && irq_to_core) // see RULE_08
      begin
        taken_priority_level_ff <= irq_level_to_core; // see RULE_06
        taken_vector_number_ff <= cur_vec_ff; // see RULE_07
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= nxt_rdata;
  end

endmodule // itc_pending_ctrl

/* itc_pend_asserts.sv */
`timescale 1ns/1ns
`include "itc_defs.vh"
module itc_pend_asserts (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Core side
  input wire core_fixed_req,
  input wire [12:0] vector_base,
  input wire irq_to_core,
  input wire [1:0] irq_level_to_core,
  input wire [20:0] vector_addr,
  input wire reset_vector_valid
);
  // Shadow of the disable bit, so blocking is judged from the ports alone
  reg dis_ff;
  always @(posedge sys_clk)
    if (rst) dis_ff <= 1'b0;
    else if (reg_wr && reg_addr == `ITC_OFS_CTRL) dis_ff <= reg_wdata[`ITC_CTRL_DIS_BIT];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  sequence s_hold;
    reset_vector_valid ##1 reset_vector_valid ##1 !reset_vector_valid;
  endsequence
  a_ctrl_irq_bit:
  assert property (s_rd(`ITC_OFS_CTRL) |-> reg_rdata[15] == $past(irq_to_core) && reg_rdata[4])
    else $error("control read mismatch");
  a_pend5_upper:
  assert property (s_rd(`ITC_OFS_PEND5) |-> reg_rdata[15:5] == 11'h7FF) else $error("pending 5 upper bits");
  a_can2_rsvd:
  assert property (s_rd(`ITC_OFS_CAN2PRI) |-> reg_rdata[15:8] == 8'h00) else $error("priority upper bits");
  a_dis_blocks:
  assert property (dis_ff && $past(dis_ff) |-> !irq_to_core) else $error("request while disabled");
  a_reset_hold:
  assert property ($fell(rst) |-> s_hold) else $error("reset vector hold length");
  a_hold_addr:
  assert property (reset_vector_valid && !$past(rst) |-> vector_addr == {$past(vector_base), 8'h00})
    else $error("reset vector address");
  a_fixed_top:
  assert property (irq_to_core && $past(core_fixed_req) |-> irq_level_to_core == 2'b11)
    else $error("fixed source not on top");
  a_vec_base:
  assert property (irq_to_core && !reset_vector_valid && $stable(vector_base)
    |-> vector_addr[20:8] == vector_base && !vector_addr[0]) else $error("vector base bits");
endmodule // itc_pend_asserts
bind itc_pending_ctrl itc_pend_asserts chk (.*);

/* itc_core_model.sv */
`timescale 1ns/1ns
module itc_core_model (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Request and permission to jump
  input wire irq_to_core,
  input wire arm,
  // Jump to service routine
  output reg core_take
);
  // Takes only a presented request; arming late models a slow core
  always @(posedge sys_clk)
    if (rst) core_take <= 1'b0;
    else core_take <= arm && irq_to_core && !core_take;
endmodule // itc_core_model

/* itc_pending_ctrl_tb_top.sv */
`timescale 1ns/1ns
`include "itc_defs.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module itc_pending_ctrl_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, core_fixed_req = 1'b0, arm = 1'b0;
  logic ext_request_a_pin_n = 1'b1, ext_request_b_pin_n = 1'b1, stop_wait_mode = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [52:0] src_req = 53'h0;
  logic [105:0] src_level = 106'h0;
  logic [12:0] vector_base = 13'h0ABC;
  logic [15:0] pri_tab [3] = '{16'h00C4, 16'h0060, 16'h0014};
  wire [15:0] reg_rdata;
  wire irq_to_core, core_take, reset_vector_valid;
  wire [1:0] irq_level_to_core;
  wire [20:0] vector_addr;
  int fails = 0, tests_run = 0;
  itc_pending_ctrl dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .src_level(src_level),
    .core_fixed_req(core_fixed_req), .core_fixed_vec(7'h05), .ext_request_a_pin_n(ext_request_a_pin_n),
    .ext_request_b_pin_n(ext_request_b_pin_n), .stop_wait_mode(stop_wait_mode), .vector_base(vector_base),
    .core_take(core_take), .irq_to_core(irq_to_core), .irq_level_to_core(irq_level_to_core),
    .vector_addr(vector_addr), .reset_vector_valid(reset_vector_valid));
  itc_core_model core (.sys_clk(sys_clk), .rst(rst), .irq_to_core(irq_to_core), .arm(arm),
    .core_take(core_take));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input [4:0] a, input [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input [4:0] a, input [15:0] e, input [15:0] m, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
    `CHK(n, e, reg_rdata & m)
  endtask
  task automatic irq_chk(input [1:0] lv, input [6:0] v, input string n);
    `CHK(n, {1'b1, lv, vector_base, v, 1'b0}, {irq_to_core, irq_level_to_core, vector_addr})
  endtask
  task automatic take;
    arm <= 1'b1;
    cyc(1);
    arm <= 1'b0;
  endtask
  task automatic t_reset;
    rst <= 1'b0;
    cyc(2);
    `CHK("hold", {1'b1, vector_base, 8'h00}, {reset_vector_valid, vector_addr})
    cyc(1);
    `CHK("hold_end", 2'b00, {reset_vector_valid, irq_to_core})
    rdc(`ITC_OFS_CTRL, 16'h001C, 16'hFFFF, "ctl");
    rdc(`ITC_OFS_CAN2PRI, 16'h0000, 16'hFFFF, "pri");
    for (int i = 0; i < 4; i++) rdc(5'(`ITC_OFS_PEND2 + i), 16'hFFFF, 16'hFFFF, "pend");
    rdc(5'h1E, 16'h0000, 16'hFFFF, "unmapped");
    wr(`ITC_OFS_CTRL, 16'hFFFF);
    rdc(`ITC_OFS_CTRL, 16'h003F, 16'hFFFF, "ctl_ro");
    wr(`ITC_OFS_CTRL, 16'h0000);
    wr(`ITC_OFS_CAN2PRI, 16'hFFFF);
    rdc(`ITC_OFS_CAN2PRI, 16'h00FF, 16'hFFFF, "pri_rsv");
    wr(`ITC_OFS_PEND5, 16'h0000);
    rdc(`ITC_OFS_PEND5, 16'hFFFF, 16'hFFFF, "pend5_ro");
    $display("reset and access test done");
  endtask
  task automatic t_can2;
    for (int f = 0; f < 4; f++)
    begin
      wr(`ITC_OFS_CAN2PRI, 16'h0000);
      src_req <= 53'h1 << (49 + f);
      cyc(3);
      `CHK("off", 1'b0, irq_to_core)
      rdc(`ITC_OFS_PEND5, ~(16'h0002 << f), 16'hFFFF, "pend5");
      wr(`ITC_OFS_CAN2PRI, 16'h0001 << (2 * f));
      cyc(3);
      irq_chk(2'b01, 7'(82 + f), "can2");
      take();
      src_req <= 53'h0;
      cyc(4);
      rdc(`ITC_OFS_CTRL, {3'b001, 7'(82 + f), 6'h1C}, 16'hFFFF, "taken");
    end
    src_req <= {4'hF, 49'h0};
    for (int k = 0; k < 3; k++)
    begin
      wr(`ITC_OFS_CAN2PRI, pri_tab[k]);
      cyc(3);
      irq_chk(2'(3 - k), 7'(85 - k), "prio");
    end
    wr(`ITC_OFS_CTRL, 16'h0020);
    cyc(3);
    `CHK("dis", 1'b0, irq_to_core)
    wr(`ITC_OFS_CTRL, 16'h0000);
    core_fixed_req <= 1'b1;
    cyc(3);
    irq_chk(2'b11, 7'h05, "fixed");
    core_fixed_req <= 1'b0;
    src_req <= 53'h0;
    $display("priority test done");
  endtask
  task automatic pulse;
    ext_request_a_pin_n <= 1'b0;
    cyc(3);
    ext_request_a_pin_n <= 1'b1;
    cyc(6);
  endtask
  task automatic t_pins;
    wr(`ITC_OFS_CAN2PRI, 16'h0000);
    src_level <= 106'h1;
    ext_request_a_pin_n <= 1'b0;
    cyc(6);
    irq_chk(2'b01, 7'h21, "pin_lvl");
    rdc(`ITC_OFS_PEND2, 16'hFFFE, 16'hFFFF, "pend2");
    rdc(`ITC_OFS_CTRL, 16'h0008, 16'h000C, "pins");
    ext_request_b_pin_n <= 1'b0;
    cyc(4);
    rdc(`ITC_OFS_CTRL, 16'h0000, 16'h000C, "pins_b");
    ext_request_b_pin_n <= 1'b1;
    ext_request_a_pin_n <= 1'b1;
    wr(`ITC_OFS_CTRL, 16'h0001);
    cyc(6);
    `CHK("pin_idle", 1'b0, irq_to_core)
    pulse();
    irq_chk(2'b01, 7'h21, "edge");
    take();
    cyc(4);
    `CHK("edge_clr", 1'b0, irq_to_core)
    stop_wait_mode <= 1'b1;
    pulse();
    `CHK("stop_lvl", 1'b0, irq_to_core)
    $display("pin test done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
  initial
  begin
    cyc(12);
    t_reset();
    t_can2();
    t_pins();
    wrap_up();
  end
endmodule // itc_pending_ctrl_tb_top
